/* File: hdl/cache_lock_ctrl.sv */
// Cache lock, default mode, invalidate-all and branch cache control
`timescale 1ns/1ps
`default_nettype none
module cache_lock_ctrl #(
   parameter int NUM_SETS = cache_lock_pkg::NUM_SETS_DEF
) (
   input  wire logic                        i_mclk,
   input  wire logic                        i_resetn,
   input  wire logic                        i_cc_wr,
   input  wire logic [31:0]                 i_cc_wdata,
   output logic      [31:0]                 o_cc_rdata,
   input  wire logic                        i_fill_req,
   input  wire logic [3:0]                  i_set_valid,
   output logic                             o_fill_vld,
   output logic      [1:0]                  o_fill_way,
   input  wire logic                        i_acc_req,
   input  wire logic                        i_lmw_hit,
   input  wire logic                        i_acw_hit,
   input  wire cache_lock_pkg::dcache_mode_t i_win_mode,
   output logic                             o_acc_vld,
   output cache_lock_pkg::dcache_mode_t     o_acc_mode,
   input  wire logic                        i_upd_req,
   input  wire logic [1:0]                  i_upd_way,
   output logic                             o_upd_go,
   output logic      [1:0]                  o_upd_way,
   output logic                             o_data_stall,
   output logic                             o_sweep_clr,
   output logic [$clog2(NUM_SETS)-1:0]      o_sweep_set,
   output logic                             o_branch_en,
   output logic                             o_branch_inval
);
   import cache_lock_pkg::*;

   // ==========================================================
   // State
   localparam int              SET_W    = $clog2(NUM_SETS);
   localparam logic [SET_W-1:0] LAST_SET = SET_W'(NUM_SETS - 1);
   localparam logic [SET_W-1:0] SET_ONE  = SET_W'(1);

   typedef struct packed {
      sweep_state_t     sweep;
      logic [SET_W-1:0] sweep_set;
      logic             stall;
      logic             inva;
      logic             half_lock;
      dcache_mode_t     dcm;
      logic             bpe;
      logic             binv;
      logic [1:0]       rr;
      logic             fill_vld;
      logic [1:0]       fill_way;
      logic             acc_vld;
      dcache_mode_t     acc_mode;
      logic             upd_go;
      logic [1:0]       upd_way;
      logic [31:0]      rdata;
   } state_t;

   localparam state_t ST_RESET = '{
      sweep:    SWEEP_IDLE,
      dcm:      MODE_WT_IMPRECISE,
      acc_mode: MODE_WT_IMPRECISE,
      rdata:    CC_RESET,
      default:  '0
   };

   state_t st_ff;
   state_t nxt_st;
   logic   busy;

   // Lowest-numbered invalid way of a set
   function automatic logic [1:0] lowest_invalid(input logic [3:0] vld);
      logic [1:0] way;
      way = 2'h3;
      for (int w = NUM_WAYS - 1; w >= 0; w--) begin
         if (!vld[w]) begin
            way = 2'(w);
         end
      end
      return way;
   endfunction

   // ==========================================================
   // Next state
   always_comb begin
      nxt_st          = st_ff;
      nxt_st.fill_vld = 1'b0;
      nxt_st.acc_vld  = 1'b0;
      nxt_st.upd_go   = 1'b0;
      nxt_st.binv     = 1'b0;
      busy            = (st_ff.sweep == SWEEP_RUN);

      // Sweep one set per cycle, then drop the invalidate bit
      case (st_ff.sweep)
         SWEEP_RUN: begin
            if (st_ff.sweep_set == LAST_SET) begin
               nxt_st.sweep = SWEEP_IDLE;
               nxt_st.inva  = 1'b0;
            end else begin
               nxt_st.sweep_set = st_ff.sweep_set + SET_ONE;
            end
         end
         SWEEP_IDLE: begin
            nxt_st.sweep = SWEEP_IDLE;
         end
         default: begin
            nxt_st.sweep = SWEEP_IDLE;
         end
      endcase

      // Register write; a new invalidate wins over the self-clear
      if (i_cc_wr) begin
         nxt_st.half_lock = i_cc_wdata[HALF_LOCK_BIT];
         nxt_st.dcm       = dcache_mode_t'(i_cc_wdata[DCM_MSB:DCM_LSB]);
         nxt_st.bpe       = i_cc_wdata[BPE_BIT];
         nxt_st.binv      = i_cc_wdata[BINV_BIT];
         if (i_cc_wdata[INVA_BIT]) begin
            nxt_st.sweep     = SWEEP_RUN;
            nxt_st.sweep_set = '0;
            nxt_st.inva      = 1'b1;
         end
      end
      nxt_st.stall = (nxt_st.sweep == SWEEP_RUN);

      // Fill way selection
      if (i_fill_req && !busy) begin
         nxt_st.fill_vld = 1'b1;
         if (st_ff.half_lock) begin
            if (&i_set_valid[3:2]) begin
               nxt_st.fill_way = {1'b1, st_ff.rr[1]};
               nxt_st.rr       = {~st_ff.rr[1], st_ff.rr[0]};
            end else begin
               nxt_st.fill_way = lowest_invalid(i_set_valid | LOCKED_WAYS);
            end
         end else if (&i_set_valid) begin
            nxt_st.fill_way = st_ff.rr;
            nxt_st.rr       = st_ff.rr + RR_STEP;
         end else begin
            nxt_st.fill_way = lowest_invalid(i_set_valid);
         end
      end

      // Effective mode of a data access
      if (i_acc_req && !busy) begin
         nxt_st.acc_vld = 1'b1;
         if (i_lmw_hit || i_acw_hit) begin
            nxt_st.acc_mode = i_win_mode;
         end else begin
            nxt_st.acc_mode = st_ff.dcm;
         end
      end

      // Write hits and explicit line ops reach any way, locked or not
      if (i_upd_req && !busy) begin
         nxt_st.upd_go  = 1'b1;
         nxt_st.upd_way = i_upd_way;
      end

      // Readback; reserved and lower bits read zero
      nxt_st.rdata                  = CC_RESET;
      nxt_st.rdata[HALF_LOCK_BIT]   = nxt_st.half_lock;
      nxt_st.rdata[DCM_MSB:DCM_LSB] = nxt_st.dcm;
      nxt_st.rdata[INVA_BIT]        = nxt_st.inva;
      nxt_st.rdata[BPE_BIT]         = nxt_st.bpe;
   end

   // ==========================================================
   // Registers; reset leaves cache arrays alone, no sweep starts
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_ff <= ST_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_cc_rdata     = st_ff.rdata;
   assign o_fill_vld     = st_ff.fill_vld;
   assign o_fill_way     = st_ff.fill_way;
   assign o_acc_vld      = st_ff.acc_vld;
   assign o_acc_mode     = st_ff.acc_mode;
   assign o_upd_go       = st_ff.upd_go;
   assign o_upd_way      = st_ff.upd_way;
   assign o_data_stall   = st_ff.stall;
   assign o_sweep_clr    = st_ff.stall;
   assign o_sweep_set    = st_ff.sweep_set;
   assign o_branch_en    = st_ff.bpe;
   assign o_branch_inval = st_ff.binv;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);

   AST_NORMAL_LOWEST: assert property (
      (!st_ff.half_lock && i_fill_req && !busy && !i_set_valid[0])
      |=> (o_fill_vld && o_fill_way == 2'h0))
      else $error("normal fill skipped invalid way 0");

   AST_NORMAL_RR: assert property (
      (!st_ff.half_lock && i_fill_req && !busy && &i_set_valid)
      |=> (o_fill_way == $past(st_ff.rr)
           && st_ff.rr == $past(st_ff.rr) + RR_STEP))
      else $error("round-robin fill or advance wrong");

   AST_HALF_NO_LOW: assert property (
      (st_ff.half_lock && i_fill_req && !busy && !i_cc_wr)
      |=> (o_fill_vld && o_fill_way[1]))
      else $error("half-lock fill went to way 0 or 1");

   AST_HALF_LOWER: assert property (
      (st_ff.half_lock && i_fill_req && !busy && !i_set_valid[2])
      |=> o_fill_way == 2'h2)
      else $error("half-lock fill skipped invalid way 2");

   AST_HALF_RR: assert property (
      (st_ff.half_lock && i_fill_req && !busy && &i_set_valid[3:2])
      |=> (o_fill_way == {1'b1, $past(st_ff.rr[1])}
           && st_ff.rr[1] != $past(st_ff.rr[1])))
      else $error("half-lock round-robin choice wrong");

   AST_UPD_LOCKED: assert property (
      (i_upd_req && !busy)
      |=> (o_upd_go && o_upd_way == $past(i_upd_way)))
      else $error("way update refused");

   AST_LOCK_ANYTIME: assert property (
      i_cc_wr |=> (st_ff.half_lock == $past(i_cc_wdata[HALF_LOCK_BIT])
                   && o_cc_rdata[HALF_LOCK_BIT] == st_ff.half_lock))
      else $error("half-lock write not taken");

   AST_DEFAULT_MODE: assert property (
      (i_acc_req && !busy && !i_lmw_hit && !i_acw_hit)
      |=> (o_acc_vld && o_acc_mode == $past(st_ff.dcm)))
      else $error("default mode not applied");

   AST_WINDOW_MODE: assert property (
      (i_acc_req && !busy && (i_lmw_hit || i_acw_hit))
      |=> (o_acc_vld && o_acc_mode == $past(i_win_mode)))
      else $error("window mode not applied");

   AST_SWEEP_START: assert property (
      (i_cc_wr && i_cc_wdata[INVA_BIT])
      |=> (o_data_stall && o_sweep_clr && o_sweep_set == '0))
      else $error("invalidate-all did not start sweep");

   AST_NO_START: assert property (
      (!busy && !(i_cc_wr && i_cc_wdata[INVA_BIT])) |=> !o_data_stall)
      else $error("sweep started without request");

   AST_STALL_REFUSE: assert property (
      busy |=> (!o_acc_vld && !o_fill_vld && !o_upd_go))
      else $error("data access served during sweep");

   AST_SELF_CLEAR: assert property (
      (busy && o_sweep_set == LAST_SET && !i_cc_wr)
      |=> (!o_data_stall && !o_cc_rdata[INVA_BIT]))
      else $error("invalidate bit did not self-clear");

   AST_POLL: assert property (
      o_data_stall |-> o_cc_rdata[INVA_BIT])
      else $error("invalidate bit reads zero during sweep");

   AST_RESET_QUIET: assert property (
      $rose(i_resetn) |-> (!o_sweep_clr && !o_branch_inval))
      else $error("reset started an invalidation");

   AST_RESET_CLEAR: assert property (
      $rose(i_resetn) |-> (o_cc_rdata == CC_RESET && !o_branch_en))
      else $error("control register not cleared by reset");

   AST_BRANCH_EN: assert property (
      i_cc_wr |=> o_branch_en == $past(i_cc_wdata[BPE_BIT]))
      else $error("branch enable not taken");

   AST_BRANCH_INV: assert property (
      i_cc_wr |=> o_branch_inval == $past(i_cc_wdata[BINV_BIT]))
      else $error("branch invalidate pulse wrong");

   COV_HALF_RR: cover property (
      st_ff.half_lock && i_fill_req && !busy && &i_set_valid[3:2]);
   COV_SWEEP_DONE: cover property (busy ##1 !busy);
   COV_WINDOW: cover property (i_acc_req && !busy && i_acw_hit);
   COV_BRANCH_INV: cover property (o_branch_inval);
endmodule
`default_nettype wire

/* File: include/cache_lock_pkg.sv */
// Constants and types for the cache lock, mode and invalidate control
`default_nettype none
package cache_lock_pkg;
   // ==========================================================
   // Register layout of cache_control (upper half only)
   localparam int          CC_WIDTH       = 32;
   localparam int          HALF_LOCK_BIT  = 27;
   localparam int          DCM_MSB        = 26;
   localparam int          DCM_LSB        = 25;
   localparam int          INVA_BIT       = 24;
   localparam int          BPE_BIT        = 19;
   localparam int          BINV_BIT       = 18;
   localparam logic [31:0] CC_RESET       = 32'h0000_0000;

   // ==========================================================
   // Cache geometry and replacement
   localparam int          NUM_SETS_DEF   = 128;
   localparam int          NUM_WAYS       = 4;
   localparam logic [1:0]  RR_RESET       = 2'h0;
   localparam logic [1:0]  RR_STEP        = 2'h1;
   localparam logic [3:0]  LOCKED_WAYS    = 4'h3;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      MODE_WT_IMPRECISE  = 2'b00,
      MODE_COPYBACK      = 2'b01,
      MODE_CI_PRECISE    = 2'b10,
      MODE_CI_IMPRECISE  = 2'b11
   } dcache_mode_t;

   typedef enum logic [0:0] {
      SWEEP_IDLE = 1'b0,
      SWEEP_RUN  = 1'b1
   } sweep_state_t;
endpackage
`default_nettype wire

/* File: tb/test_cache_lock_mode_invalidate_ctrl.sv */
// Self-checking bench for the cache lock, mode and invalidate control
`timescale 1ns/1ps
`default_nettype none
module test_cache_lock_mode_invalidate_ctrl;
   import cache_lock_pkg::*;
   localparam int NS = 4;
   logic         i_mclk, i_resetn, cc_wr, fill_req, acc_req, lmw, acw;
   logic         upd_req, fill_vld, acc_vld, upd_go, stall, sw_clr, b_en;
   logic         b_inv;
   logic [31:0]  wdata, rdata;
   logic [3:0]   set_valid, pk;
   logic [1:0]   fill_way, upd_way, upd_way_o, sw_set, rr;
   dcache_mode_t win_mode, acc_mode;
   logic [31:0]  cc;
   int           failures, check_count;

   cache_lock_ctrl #(.NUM_SETS(NS)) dut (
      .i_mclk(i_mclk), .i_resetn(i_resetn), .i_cc_wr(cc_wr),
      .i_cc_wdata(wdata), .o_cc_rdata(rdata), .i_fill_req(fill_req),
      .i_set_valid(set_valid), .o_fill_vld(fill_vld),
      .o_fill_way(fill_way), .i_acc_req(acc_req), .i_lmw_hit(lmw),
      .i_acw_hit(acw), .i_win_mode(win_mode), .o_acc_vld(acc_vld),
      .o_acc_mode(acc_mode), .i_upd_req(upd_req), .i_upd_way(upd_way),
      .o_upd_go(upd_go), .o_upd_way(upd_way_o), .o_data_stall(stall),
      .o_sweep_clr(sw_clr), .o_sweep_set(sw_set), .o_branch_en(b_en),
      .o_branch_inval(b_inv));

   initial begin
      i_mclk = 1'b0;
      forever #20 i_mclk = ~i_mclk;
   end

   // ==========================================================
   // Expectation and comparison helpers
   function automatic logic [3:0] pick(input logic [3:0] v, input logic hl,
                                       input logic [1:0] r);
      if (!hl) begin
         for (int i = 0; i < 4; i++) if (!v[i]) return {r, 2'(i)};
         return {r + 2'h1, r};
      end
      if (!v[2]) return {r, 2'h2};
      if (!v[3]) return {r, 2'h3};
      return {~r[1], r[0], 1'b1, r[1]};
   endfunction

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // ==========================================================
   // Request tasks: drive after an edge, check after the next one
   task automatic wr(input logic [31:0] d);
      @(posedge i_mclk);
      cc_wr <= 1'b1;
      wdata <= d;
      @(posedge i_mclk);
      cc_wr <= 1'b0;
      #1;
      cc = d & 32'h0E08_0000;
      chk("rdata", cc | (d & 32'h0100_0000), rdata);
      chk("branch_en", d[19], b_en);
      chk("branch_inval", d[18], b_inv);
   endtask

   task automatic fill(input logic [3:0] v);
      @(posedge i_mclk);
      fill_req <= 1'b1;
      set_valid <= v;
      @(posedge i_mclk);
      fill_req <= 1'b0;
      #1;
      pk = pick(v, cc[27], rr);
      rr = pk[3:2];
      chk("fill_vld", 1, fill_vld);
      chk("fill_way", pk[1:0], fill_way);
   endtask

   task automatic acc(input logic l, input logic a, input dcache_mode_t m);
      @(posedge i_mclk);
      acc_req <= 1'b1;
      lmw <= l;
      acw <= a;
      win_mode <= m;
      @(posedge i_mclk);
      acc_req <= 1'b0;
      #1;
      chk("acc_vld", 1, acc_vld);
      chk("acc_mode", (l | a) ? m : cc[26:25], acc_mode);
   endtask

   task automatic upd(input logic [1:0] w);
      @(posedge i_mclk);
      upd_req <= 1'b1;
      upd_way <= w;
      @(posedge i_mclk);
      upd_req <= 1'b0;
      #1;
      chk("upd_go", 1, upd_go);
      chk("upd_way", w, upd_way_o);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      {cc_wr, fill_req, acc_req, lmw, acw, upd_req} = '0;
      wdata = '0;
      set_valid = '0;
      upd_way = '0;
      win_mode = MODE_WT_IMPRECISE;
      failures = 0;
      check_count = 0;
      rr = RR_RESET;
      cc = '0;
      void'($urandom(47977));
      i_resetn = 1'b0;
      repeat (3) @(posedge i_mclk);
      #1;
      chk("rdata", 0, rdata);
      chk("stall", 0, stall);
      chk("branch_inval", 0, b_inv);
      @(posedge i_mclk);
      i_resetn <= 1'b1;
      $display("test reset done");

      fill(4'h0);
      for (int i = 0; i < 6; i++) fill(4'hF);
      fill(4'hB);
      wr(32'h0800_0000);
      fill(4'h0);
      fill(4'h3);
      fill(4'hB);
      for (int i = 0; i < 4; i++) fill(4'hF);
      for (int i = 0; i < 4; i++) upd(2'(i));
      $display("test fill done");

      for (int m = 0; m < 4; m++) begin
         wr(32'(m) << 25);
         acc(1'b0, 1'b0, MODE_CI_IMPRECISE);
         acc(1'b1, 1'b0, dcache_mode_t'(~m));
         acc(1'b0, 1'b1, dcache_mode_t'(m + 1));
      end
      $display("test mode done");

      wr(32'h0D0C_0000);
      chk("stall", 1, stall);
      chk("sweep_set", 0, sw_set);
      for (int k = 1; k < NS; k++) begin
         @(posedge i_mclk);
         fill_req <= (k == 1);
         acc_req <= (k == 1);
         upd_req <= (k == 2);
         #1;
         chk("acc_vld", 0, acc_vld);
         chk("upd_go", 0, upd_go);
         chk("sweep_set", k, sw_set);
         chk("sweep_clr", 1, sw_clr);
         chk("rdata", cc | 32'h0100_0000, rdata);
         chk("fill_vld", 0, fill_vld);
      end
      @(posedge i_mclk);
      #1;
      chk("stall", 0, stall);
      chk("rdata", cc, rdata);
      chk("fill_vld", 0, fill_vld);
      chk("upd_go", 0, upd_go);
      wr(32'h0000_0000);
      chk("stall", 0, stall);
      $display("test sweep done");

      for (int n = 0; n < 60; n++) begin
         case ($urandom % 4)
            0: wr($urandom & 32'h0E0C_0000);
            1: fill(4'($urandom));
            2: acc(1'($urandom), 1'($urandom),
                   dcache_mode_t'(2'($urandom)));
            default: upd(2'($urandom));
         endcase
      end
      $display("test random done");

      // Reset in mid-sweep: register clears, no sweep, counter restarts
      for (int i = 0; i < 4; i++) upd(2'(i));
      wr(32'h0108_0000);
      @(posedge i_mclk);
      i_resetn <= 1'b0;
      #1;
      chk("rdata", 0, rdata);
      chk("stall", 0, stall);
      chk("branch_en", 0, b_en);
      @(posedge i_mclk);
      i_resetn <= 1'b1;
      rr = RR_RESET;
      cc = '0;
      fill(4'hF);
      $display("test mid reset done");
      print_verdict();
   end

   initial begin
      repeat (5000) @(posedge i_mclk);
      failures++;
      print_verdict();
   end
endmodule
`default_nettype wire
